// >>> logic/smsp_top.sv
// Host SPI port, stack bus relay, reset and power control of the monitor
//
// Function
// - Lockout: stop analog, clear balance, flag
// - Power-on reset: halt, defaults, flag, no address
// - Code a5 to reset register resets
// - Broadcast reset obeyed without valid address
// - Overheat: regulator off, converter off, sleep
// - Overheat keeps auxiliary and protection off
// - Sleep turns sensor regulator off
// - Auxiliary output follows its enable bit outside sleep and overheat
// - General pin follows drive bit, readable
// - Host port SPI mode 1
// - All shifting most significant bit first
// - Non-base device drives host select, clock and data-in pins low
// - Host data out driven only when sending or relaying
// - South to lower, north to higher device
// - Stack select, clock and data quiet while host deselected
// - Stack select active high, idles low
// - Clock and data forwarded without inversion
// - Stack data outputs low when idle
// - Read data south, relayed, host on base
// - Data supplier appends CRC byte
// - CRC-8 poly 07 over whole packet
// - Read packet: address/rw, offset, length, data, CRC; write: address/rw, offset, data, CRC
// - Address zero blocks north select
`timescale 1ns/1ps
module smsp_top
	import smsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic low_supply_lockout_i,
	input wire logic power_on_reset_i,
	input wire logic overheat_shutdown_i,
	input wire logic nonbase_strap_i,
	input wire logic conversion_done_i,
	input wire logic host_cs_n_i,
	output logic host_cs_n_o,
	output logic host_cs_n_oe_o,
	input wire logic host_sclk_i,
	output logic host_sclk_o,
	output logic host_sclk_oe_o,
	input wire logic host_data_in_pin_i,
	output logic host_data_in_pin_o,
	output logic host_data_in_pin_oe_o,
	output logic host_data_out_pin_o,
	output logic host_data_out_pin_oe_o,
	input wire smsp_stack_t south_i,
	output logic south_data_out_o,
	output logic south_conversion_done_o,
	output smsp_stack_t north_o,
	input wire logic north_data_out_i,
	input wire logic north_conversion_done_i,
	input wire logic gpio_i,
	output logic gpio_o,
	output logic gpio_oe_o,
	output logic conversion_trigger_o,
	output logic sensor_supply_regulator_en_o,
	output logic aux_supply_en_o,
	output logic converter_en_o,
	output logic fault_detect_en_o,
	output logic secondary_prot_en_o,
	output logic [5:0] balance_o
);
	logic lock_s, por_s, hot_s, strap_s, gpio_s, done_n_s, north_data_out_s;
	logic hcs_n_s, hsclk_s, hsdi_s;
	smsp_stack_t south_s;

	// Every pin but conversion_done_i and rst_i is synchronised to clk_i, the link clock included
	smsp_sync #(
		.W(14)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({low_supply_lockout_i, power_on_reset_i, overheat_shutdown_i,
			nonbase_strap_i, gpio_i, north_conversion_done_i,
			north_data_out_i, south_i, host_cs_n_i, host_sclk_i,
			host_data_in_pin_i}),
		.q_o({lock_s, por_s, hot_s, strap_s, gpio_s, done_n_s, north_data_out_s,
			south_s, hcs_n_s, hsclk_s, hsdi_s})
	);

	logic [11:0] soft_cnt_q;
	logic [7:0] io_q, bal_q, addr_q, fault_q, alert_q;
	logic lock_flag_q;
	logic cs_prev_q, sclk_prev_q, tx_on_q;
	logic [2:0] bit_cnt_q;
	logic [8:0] byte_cnt_q;
	logic [7:0] rx_q, hdr_q, off_q, len_q, tx_q;
	logic [7:0] crc;

	// Power-on and command reset share one hold state
	wire in_reset = rst_i || por_s || (soft_cnt_q != 12'h000);
	wire is_base = !strap_s;
	wire [5:0] my_addr = addr_q[5:0];
	wire addr_ok = addr_q[AC_VALID] && (my_addr != ADDR_NONE);

	// Host select is active low, stack select active high
	wire src_cs = is_base ? !hcs_n_s : south_s.cs;
	wire src_sclk = is_base ? hsclk_s : south_s.sclk;
	wire src_sdi = is_base ? hsdi_s : south_s.sdi;
	wire cs_act = src_cs && !in_reset;
	wire frame_end = cs_prev_q && !cs_act;

	wire sclk_rise = cs_act && src_sclk && !sclk_prev_q;
	wire sclk_fall = cs_act && !src_sclk && sclk_prev_q;
	wire byte_done = sclk_fall && (bit_cnt_q == 3'h7);
	wire [7:0] rx_next = {rx_q[6:0], src_sdi};

	// Header byte 0 carries address and write bit
	wire is_wr = hdr_q[0];
	wire [5:0] pkt_addr = hdr_q[6:1];
	wire for_me = (pkt_addr == my_addr);
	wire bcast = (pkt_addr == ADDR_BCAST);
	wire [8:0] last_idx = {1'b0, len_q} + HDR_BYTES;
	wire past_hdr = byte_cnt_q >= HDR_BYTES;
	wire rd_mine = !is_wr && for_me && past_hdr && (byte_cnt_q <= last_idx);
	wire rd_other = !is_wr && !for_me && past_hdr;

	// Register read selection
	wire [7:0] rd_idx = off_q + byte_cnt_q[7:0] - HDR_BYTES[7:0];
	logic [7:0] dev_status, io_view;
	always_comb
	begin
		dev_status = 8'h00;
		dev_status[DS_ADDR_VALID] = addr_q[AC_VALID];
		dev_status[DS_LOCKOUT] = lock_flag_q;
		dev_status[DS_OVERHEAT] = hot_s;
		io_view = io_q;
		io_view[IO_GPIO_IN] = gpio_s;
	end
	wire [7:0] rd_byte =
		(rd_idx == OFS_DEV_STATUS) ? dev_status :
		(rd_idx == OFS_ALERT) ? alert_q :
		(rd_idx == OFS_FAULT) ? fault_q :
		(rd_idx == OFS_IO_CTRL) ? io_view :
		(rd_idx == OFS_BAL) ? bal_q :
		(rd_idx == OFS_ADDR_CTRL) ? addr_q : 8'h00;

	wire [7:0] load_byte = (byte_cnt_q == last_idx) ? crc : rd_byte;
	logic [7:0] tx_d;
	logic tx_on_d;
	always_comb
	begin
		tx_d = tx_q;
		tx_on_d = tx_on_q;
		if (!cs_act)
		begin
			tx_d = 8'h00;
			tx_on_d = 1'b0;
		end
		else if (sclk_rise && bit_cnt_q == 3'h0)
		begin
			tx_d = rd_mine ? load_byte : 8'h00;
			tx_on_d = rd_mine;
		end
		else if (sclk_rise)
			tx_d = {tx_q[6:0], 1'b0};
	end

	// CRC over header, then data sent
	wire crc_en = sclk_fall && ((byte_cnt_q < HDR_BYTES) ||
		(is_wr && byte_cnt_q < WR_BYTES) ||
		(!is_wr && for_me && byte_cnt_q < last_idx));
	wire crc_bit = (is_wr || byte_cnt_q < HDR_BYTES) ? src_sdi : tx_q[7];
	smsp_crc8 u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!cs_act),
		.en_i(crc_en),
		.bit_i(crc_bit),
		.crc_o(crc)
	);

	// write needs address, offset, data, CRC
	wire wr_ok = frame_end && is_wr && (byte_cnt_q == WR_BYTES) &&
		(crc == 8'h00);
	wire wr_hit = for_me || (bcast && addr_ok) ||
		(bcast && off_q == OFS_RESET);
	wire wr_en = wr_ok && wr_hit;
	wire wr_io = wr_en && (off_q == OFS_IO_CTRL);
	wire wr_bal = wr_en && (off_q == OFS_BAL);
	wire wr_addr = wr_en && (off_q == OFS_ADDR_CTRL);
	wire wr_fault = wr_en && (off_q == OFS_FAULT);
	wire wr_alert = wr_en && (off_q == OFS_ALERT);
	wire wr_dev = wr_en && (off_q == OFS_DEV_STATUS);
	wire soft_go = wr_en && (off_q == OFS_RESET) && (len_q == RESET_CODE);

	// Frame shifter
	always_ff @(posedge clk_i)
	begin
		if (in_reset || !cs_act)
		begin
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 9'h000;
			rx_q <= 8'h00;
			if (in_reset)
			begin
				hdr_q <= 8'h00;
				off_q <= 8'h00;
				len_q <= 8'h00;
			end
		end
		else if (sclk_fall)
		begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			rx_q <= rx_next;
			if (byte_done)
			begin
				byte_cnt_q <= byte_cnt_q + 9'h001;
				if (byte_cnt_q == 9'h000)
					hdr_q <= rx_next;
				if (byte_cnt_q == 9'h001)
					off_q <= rx_next;
				if (byte_cnt_q == 9'h002)
					len_q <= rx_next;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		cs_prev_q <= cs_act;
		sclk_prev_q <= src_sclk;
		tx_q <= tx_d;
		tx_on_q <= tx_on_d;
		if (rst_i)
			soft_cnt_q <= 12'h000;
		else if (soft_go)
			soft_cnt_q <= SOFT_RST_CNT;
		else if (soft_cnt_q != 12'h000)
			soft_cnt_q <= soft_cnt_q - 12'h001;
	end

	// Registers; hardware set wins over a software clear
	always_ff @(posedge clk_i)
	begin
		if (in_reset)
		begin
			io_q <= IO_CTRL_RST;
			bal_q <= BAL_RST;
			addr_q <= ADDR_CTRL_RST;
			fault_q <= FAULT_RST;
			alert_q <= ALERT_RST;
			lock_flag_q <= 1'b0;
		end
		else
		begin
			if (wr_io)
				io_q <= len_q;
			if (hot_s)
				io_q[IO_SLEEP] <= 1'b1;
			if (lock_s)
				bal_q <= 8'h00;
			else if (wr_bal)
				bal_q <= len_q;
			if (wr_addr)
				addr_q <= len_q;
			if (wr_fault)
				fault_q <= fault_q & ~len_q;
			if (wr_alert)
				alert_q <= alert_q & ~len_q;
			if (hot_s)
			begin
				alert_q[AS_OVERHEAT] <= 1'b1;
				alert_q[AS_SLEEP] <= 1'b1;
			end
			if (wr_dev && len_q[DS_LOCKOUT])
				lock_flag_q <= 1'b0;
			if (lock_s)
				lock_flag_q <= 1'b1;
		end
	end

	// Outgoing data: own bits when sending, else relay from north
	wire dout = tx_on_d ? tx_d[7] : north_data_out_s;
	wire fwd = cs_act && addr_ok;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			north_o <= '0;
			south_data_out_o <= 1'b0;
			host_data_out_pin_o <= 1'b0;
			host_data_out_pin_oe_o <= 1'b0;
			host_cs_n_o <= 1'b0;
			host_cs_n_oe_o <= 1'b0;
			host_sclk_o <= 1'b0;
			host_sclk_oe_o <= 1'b0;
			host_data_in_pin_o <= 1'b0;
			host_data_in_pin_oe_o <= 1'b0;
			south_conversion_done_o <= 1'b0;
			conversion_trigger_o <= 1'b0;
		end
		else
		begin
			// address zero holds north select low
			// forward select, clock and data north
			north_o.cs <= fwd;
			north_o.sclk <= fwd && src_sclk;
			north_o.sdi <= fwd && src_sdi;
			// trigger up, done down the stack
			north_o.conversion_trigger <= !in_reset && south_s.conversion_trigger;
			conversion_trigger_o <= !in_reset && south_s.conversion_trigger;
			south_conversion_done_o <= !in_reset && done_n_s &&
				conversion_done_i;
			south_data_out_o <= !is_base && cs_act && (tx_on_d || rd_other) &&
				dout;
			// host data out driven only while sending or relaying
			host_data_out_pin_o <= is_base && dout;
			host_data_out_pin_oe_o <= is_base && cs_act &&
				(tx_on_d || rd_other);
			host_cs_n_o <= 1'b0;
			host_cs_n_oe_o <= !is_base;
			host_sclk_o <= 1'b0;
			host_sclk_oe_o <= !is_base;
			host_data_in_pin_o <= 1'b0;
			host_data_in_pin_oe_o <= !is_base;
		end
	end

	// Power and pin control
	always_ff @(posedge clk_i)
	begin
		if (in_reset)
		begin
			sensor_supply_regulator_en_o <= 1'b0;
			aux_supply_en_o <= 1'b0;
			converter_en_o <= 1'b0;
			fault_detect_en_o <= 1'b0;
			secondary_prot_en_o <= 1'b0;
			balance_o <= 6'h00;
			gpio_o <= 1'b0;
			gpio_oe_o <= 1'b0;
		end
		else
		begin
			// regulator off in overheat or sleep
			sensor_supply_regulator_en_o <= !hot_s && !io_q[IO_SLEEP];
			// auxiliary follows its bit, off when hot or in sleep
			aux_supply_en_o <= io_q[IO_AUX] && !hot_s && !io_q[IO_SLEEP];
			converter_en_o <= !hot_s && !lock_s;
			fault_detect_en_o <= !lock_s;
			secondary_prot_en_o <= !hot_s && !lock_s;
			balance_o <= lock_s ? 6'h00 : bal_q[5:0];
			// drive bit 1 releases the pin for sensing
			gpio_o <= 1'b0;
			gpio_oe_o <= !io_q[IO_GPIO_OUT];
		end
	end
endmodule

// >>> shared/smsp_pkg.sv
// Constants, register map and carrier types of the stack monitor control
package smsp_pkg;
	localparam int unsigned CLK_MHZ = 10;
	localparam int unsigned SOFT_RST_US = 300;
	localparam int unsigned SOFT_RST_CYC = SOFT_RST_US * CLK_MHZ;
	localparam logic [11:0] SOFT_RST_CNT = 12'(SOFT_RST_CYC);

	localparam logic [7:0] RESET_CODE = 8'ha5;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [5:0] ADDR_BCAST = 6'h3f;
	localparam logic [5:0] ADDR_NONE = 6'h00;
	localparam logic [8:0] HDR_BYTES = 9'h003;
	localparam logic [8:0] WR_BYTES = 9'h004;

	// Register offsets
	localparam logic [7:0] OFS_DEV_STATUS = 8'h00;
	localparam logic [7:0] OFS_ALERT = 8'h02;
	localparam logic [7:0] OFS_FAULT = 8'h03;
	localparam logic [7:0] OFS_IO_CTRL = 8'h31;
	localparam logic [7:0] OFS_BAL = 8'h32;
	localparam logic [7:0] OFS_ADDR_CTRL = 8'h3b;
	localparam logic [7:0] OFS_RESET = 8'h3c;

	// Field positions
	localparam int unsigned DS_ADDR_VALID = 7;
	localparam int unsigned DS_LOCKOUT = 6;
	localparam int unsigned DS_OVERHEAT = 5;
	localparam int unsigned FS_POR = 3;
	localparam int unsigned AS_OVERHEAT = 3;
	localparam int unsigned AS_SLEEP = 2;
	localparam int unsigned IO_AUX = 7;
	localparam int unsigned IO_GPIO_OUT = 6;
	localparam int unsigned IO_GPIO_IN = 5;
	localparam int unsigned IO_SLEEP = 2;
	localparam int unsigned AC_VALID = 7;

	// Reset values
	localparam logic [7:0] IO_CTRL_RST = 8'h00;
	localparam logic [7:0] BAL_RST = 8'h00;
	localparam logic [7:0] ADDR_CTRL_RST = 8'h00;
	localparam logic [7:0] FAULT_RST = 8'h08;
	localparam logic [7:0] ALERT_RST = 8'h00;

	typedef struct packed {
		logic cs;
		logic sclk;
		logic sdi;
		logic conversion_trigger;
	} smsp_stack_t;
endpackage

// >>> logic/smsp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module smsp_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// >>> logic/smsp_crc8.sv
// Bit-serial CRC-8, most significant bit first
`timescale 1ns/1ps
module smsp_crc8
	import smsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic bit_i,
	output logic [7:0] crc_o
);
	wire fb = crc_o[7] ^ bit_i;
	wire [7:0] crc_d = {crc_o[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || clr_i)
			crc_o <= 8'h00;
		else if (en_i)
			crc_o <= crc_d;
	end
endmodule

// >>> bench/smsp_top_properties.sv
// Concurrent checks on the monitor control ports
`timescale 1ns/1ps
module smsp_top_props
	import smsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic low_supply_lockout_i,
	input wire logic power_on_reset_i,
	input wire logic overheat_shutdown_i,
	input wire logic nonbase_strap_i,
	input wire logic host_cs_n_i,
	input wire logic host_cs_n_o,
	input wire logic host_cs_n_oe_o,
	input wire logic host_data_out_pin_oe_o,
	input wire logic south_data_out_o,
	input wire smsp_stack_t north_o,
	input wire logic sensor_supply_regulator_en_o,
	input wire logic aux_supply_en_o,
	input wire logic converter_en_o,
	input wire logic fault_detect_en_o,
	input wire logic secondary_prot_en_o,
	input wire logic [5:0] balance_o
);
	// Inputs pass two sync flops, so six edges leave margin
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_lock;
		low_supply_lockout_i [*6] |-> balance_o == 6'h00
			&& !converter_en_o && !fault_detect_en_o;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lockout left outputs on");
	property p_por;
		power_on_reset_i [*6] |-> !north_o.cs
			&& !host_data_out_pin_oe_o && balance_o == 6'h00;
	endproperty
	a_por: assert property (p_por)
		else $error("activity during power-on reset");
	property p_heat;
		overheat_shutdown_i [*6] |->
			!sensor_supply_regulator_en_o && !converter_en_o;
	endproperty
	a_heat: assert property (p_heat)
		else $error("regulator or converter on in overheat");
	property p_aux;
		overheat_shutdown_i [*6] |->
			!aux_supply_en_o && !secondary_prot_en_o;
	endproperty
	a_aux: assert property (p_aux)
		else $error("aux or protection on in overheat");
	property p_strap;
		nonbase_strap_i [*6] |-> host_cs_n_oe_o && !host_cs_n_o;
	endproperty
	a_strap: assert property (p_strap)
		else $error("host pins not driven low");
	property p_sdo;
		(host_cs_n_i && !nonbase_strap_i) [*6] |->
			!host_data_out_pin_oe_o;
	endproperty
	a_sdo: assert property (p_sdo)
		else $error("host data out driven while idle");
	property p_quiet;
		(host_cs_n_i && !nonbase_strap_i) [*6] |->
			!north_o.cs && !north_o.sclk && !north_o.sdi;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("stack bus active while deselected");
	property p_south;
		!nonbase_strap_i [*6] |-> !south_data_out_o;
	endproperty
	a_south: assert property (p_south)
		else $error("south data out asserted on base");
endmodule

// >>> bench/smsp_host.sv
// Host controller model on the base device SPI pins
`timescale 1ns/1ps
module smsp_host (
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	logic [7:0] rx;
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
	// slow clock, clock and data low when idle
	task automatic sel(input logic on);
		cs_n_o = !on;
		sdi_o = 1'b0;
		#400;
	endtask
	task automatic xfer(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--)
		begin
			sclk_o = 1'b1;
			sdi_o = tx[i];
			#400 sclk_o = 1'b0;
			rx[i] = sdo_i;
			#400;
		end
		sdi_o = 1'b0;
	endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the stack monitor control block
`timescale 1ns/1ps
`define CHK(a, e) \
	begin \
		n_compared++; \
		if ((a) !== (e)) \
		begin \
			bad_count++; \
			$display("mismatch %0t got %h want %h", $time, a, e); \
		end \
	end
module tb_top
	import smsp_pkg::*;
;
	logic clk_i, rst_i, lock, por, heat, strap;
	logic hcs_o, hcs_oe, hsk_o, hsk_oe, hdi_o, hdi_oe, sdo_o, sdo_oe;
	logic mcs, msk, msd, gp_o, gp_oe, reg_en, aux_en, conversion_trigger_en;
	logic flt_en, prot_en;
	logic ndo, cdone, ndone, valid_addr, ctrig, sdone, south_data_out;
	smsp_stack_t sth;
	logic [5:0] bal;
	wire hcs, hsk, hdi, sdo, gp;
	smsp_stack_t north;
	int bad_count, n_compared, cyc;
	always #50 clk_i = ~clk_i;
	assign sdo = sdo_oe ? sdo_o : 1'b1;
	assign hcs = hcs_oe ? hcs_o : mcs;
	assign hsk = hsk_oe ? hsk_o : msk;
	assign hdi = hdi_oe ? hdi_o : msd;
	assign gp = gp_oe ? gp_o : 1'b1;
	smsp_host smsp_host_inst (.cs_n_o(mcs), .sclk_o(msk),
		.sdi_o(msd), .sdo_i(sdo));
	smsp_top smsp_top_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.low_supply_lockout_i(lock),
		.power_on_reset_i(por),
		.overheat_shutdown_i(heat),
		.nonbase_strap_i(strap),
		.conversion_done_i(cdone),
		.host_cs_n_i(hcs),
		.host_cs_n_o(hcs_o),
		.host_cs_n_oe_o(hcs_oe),
		.host_sclk_i(hsk),
		.host_sclk_o(hsk_o),
		.host_sclk_oe_o(hsk_oe),
		.host_data_in_pin_i(hdi),
		.host_data_in_pin_o(hdi_o),
		.host_data_in_pin_oe_o(hdi_oe),
		.host_data_out_pin_o(sdo_o),
		.host_data_out_pin_oe_o(sdo_oe),
		.south_i(sth),
		.south_data_out_o(south_data_out),
		.south_conversion_done_o(sdone),
		.north_o(north),
		.north_data_out_i(ndo),
		.north_conversion_done_i(ndone),
		.gpio_i(gp),
		.gpio_o(gp_o),
		.gpio_oe_o(gp_oe),
		.conversion_trigger_o(ctrig),
		.sensor_supply_regulator_en_o(reg_en),
		.aux_supply_en_o(aux_en),
		.converter_en_o(conversion_trigger_en),
		.fault_detect_en_o(flt_en),
		.secondary_prot_en_o(prot_en),
		.balance_o(bal)
	);
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	function automatic logic [7:0] crc8(input logic [31:0] v,
		input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = n * 8 - 1; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	// header bytes, then read data and check byte
	task automatic pkt(input logic [23:0] hd, input logic is_rd,
		output logic [7:0] d);
		d = 8'h00;
		smsp_host_inst.sel(1'b1);
		for (int i = 2; i >= 0; i--)
			smsp_host_inst.xfer(hd[i * 8 +: 8]);
		if (is_rd)
		begin
			smsp_host_inst.xfer(8'h00);
			d = smsp_host_inst.rx;
			smsp_host_inst.xfer(8'h00);
			`CHK(smsp_host_inst.rx, crc8({hd, d}, 4))
		end
		else
			smsp_host_inst.xfer(crc8({8'h00, hd}, 3));
		`CHK(north.cs, valid_addr)
		smsp_host_inst.sel(1'b0);
		w(6);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] o, v);
		logic [7:0] d;
		pkt({1'b0, a, 1'b1, o, v}, 1'b0, d);
	endtask
	task automatic rd(input logic [7:0] o, e);
		logic [7:0] d;
		pkt({8'h00, o, 8'h01}, 1'b1, d);
		`CHK(d, e)
	endtask
	task automatic t_boot();
		`CHK(reg_en, 1'b1)
		`CHK(aux_en, 1'b0)
		`CHK(gp_oe, 1'b1)
		rd(OFS_FAULT, FAULT_RST);
		rd(OFS_ADDR_CTRL, 8'h00);
		$display("done boot");
	endtask
	task automatic t_io();
		wr(6'h00, OFS_IO_CTRL, 8'hc0);
		`CHK(aux_en, 1'b1)
		`CHK(gp_oe, 1'b0)
		rd(OFS_IO_CTRL, 8'he0);
		wr(6'h00, OFS_IO_CTRL, 8'h80);
		`CHK(gp_oe, 1'b1)
		$display("done io");
	endtask
	task automatic t_heat();
		heat = 1'b1;
		w(8);
		`CHK(reg_en, 1'b0)
		`CHK(conversion_trigger_en, 1'b0)
		`CHK(aux_en, 1'b0)
		`CHK(prot_en, 1'b0)
		rd(OFS_ALERT, 8'h0c);
		heat = 1'b0;
		w(8);
		`CHK(reg_en, 1'b0)
		rd(OFS_IO_CTRL, 8'h84);
		wr(6'h00, OFS_IO_CTRL, 8'h80);
		`CHK(reg_en, 1'b1)
		$display("done heat");
	endtask
	task automatic t_lock();
		wr(6'h00, OFS_BAL, 8'h15);
		`CHK(bal, 6'h15)
		lock = 1'b1;
		w(8);
		`CHK(bal, 6'h00)
		`CHK(conversion_trigger_en, 1'b0)
		`CHK(flt_en, 1'b0)
		rd(OFS_BAL, 8'h00);
		lock = 1'b0;
		w(8);
		rd(OFS_DEV_STATUS, 8'h40);
		$display("done lock");
	endtask
	task automatic t_rst();
		wr(6'h00, OFS_FAULT, 8'h08);
		rd(OFS_FAULT, 8'h00);
		wr(ADDR_BCAST, OFS_RESET, RESET_CODE);
		`CHK(aux_en, 1'b0)
		w(SOFT_RST_CYC + 8);
		rd(OFS_FAULT, FAULT_RST);
		rd(OFS_IO_CTRL, 8'h00);
		wr(6'h00, OFS_FAULT, 8'h08);
		por = 1'b1;
		w(8);
		por = 1'b0;
		w(8);
		rd(OFS_FAULT, FAULT_RST);
		$display("done reset");
	endtask
	task automatic t_addr();
		logic [7:0] d;
		wr(6'h00, OFS_ADDR_CTRL, 8'h81);
		valid_addr = 1'b1;
		pkt({8'h02, OFS_ADDR_CTRL, 8'h01}, 1'b1, d);
		`CHK(d, 8'h81)
		`CHK(north.cs, 1'b0)
		smsp_host_inst.sel(1'b1);
		`CHK(north.cs, 1'b1)
		// Read for address 0, another device, is relayed from north
		smsp_host_inst.xfer(8'h00);
		smsp_host_inst.xfer(OFS_DEV_STATUS);
		smsp_host_inst.xfer(8'h02);
		smsp_host_inst.xfer(8'h00);
		`CHK(smsp_host_inst.rx, 8'h00)
		ndo = 1'b1;
		smsp_host_inst.xfer(8'h00);
		`CHK(smsp_host_inst.rx, 8'hff)
		smsp_host_inst.sel(1'b0);
		ndo = 1'b0;
		w(6);
		`CHK(sdo_oe, 1'b0)
		$display("done addr");
	endtask
	task automatic t_conversion_trigger();
		sth.conversion_trigger = 1'b1;
		w(4);
		`CHK(ctrig, 1'b1)
		`CHK(north.conversion_trigger, 1'b1)
		sth.conversion_trigger = 1'b0;
		cdone = 1'b1;
		w(4);
		`CHK(ctrig, 1'b0)
		`CHK(sdone, 1'b0)
		ndone = 1'b1;
		w(4);
		`CHK(sdone, 1'b1)
		cdone = 1'b0;
		w(4);
		`CHK(sdone, 1'b0)
		ndone = 1'b0;
		$display("done conversion_trigger");
	endtask
	task automatic t_strap();
		strap = 1'b1;
		w(8);
		`CHK(south_data_out, 1'b0)
		`CHK(hsk_oe, 1'b1)
		`CHK(hsk_o, 1'b0)
		`CHK(hdi_oe, 1'b1)
		strap = 1'b0;
		w(8);
		$display("done strap");
	endtask
	initial
	begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		lock = 1'b0;
		por = 1'b0;
		heat = 1'b0;
		strap = 1'b0;
		ndo = 1'b0;
		cdone = 1'b0;
		ndone = 1'b0;
		valid_addr = 1'b0;
		sth = '0;
		w(6);
		rst_i = 1'b0;
		w(6);
		t_boot();
		t_io();
		t_heat();
		t_lock();
		t_rst();
		t_conversion_trigger();
		t_addr();
		t_strap();
		tally_and_finish();
	end
endmodule
bind smsp_top smsp_top_props smsp_top_props_inst (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.low_supply_lockout_i(low_supply_lockout_i),
	.power_on_reset_i(power_on_reset_i),
	.overheat_shutdown_i(overheat_shutdown_i),
	.nonbase_strap_i(nonbase_strap_i),
	.host_cs_n_i(host_cs_n_i),
	.host_cs_n_o(host_cs_n_o),
	.host_cs_n_oe_o(host_cs_n_oe_o),
	.host_data_out_pin_oe_o(host_data_out_pin_oe_o),
	.south_data_out_o(south_data_out_o),
	.north_o(north_o),
	.sensor_supply_regulator_en_o(sensor_supply_regulator_en_o),
	.aux_supply_en_o(aux_supply_en_o),
	.converter_en_o(converter_en_o),
	.fault_detect_en_o(fault_detect_en_o),
	.secondary_prot_en_o(secondary_prot_en_o),
	.balance_o(balance_o)
);
